// File: verilog/mdab_defines.vh
// Notes on behaviour
// - Bank row/column enables latch: pass while RAM latch strobe high, hold while low.
// - Hold acknowledge forces the RAM decode latches transparent.
// - Refresh ignores address, forces both row enables high, both column enables low.
// - Four DRAM address bits latched, muxed onto two outputs; refresh carry replaces low.
// - ROM space decoded from upper address, latched on ALE, transparent under hold ack.
// - Peripheral bit 16 low selects ROM select zero, high selects ROM select one.
// - Two banks: select zero 0E0000-0EFFFF, select one 0F0000-0FFFFF.
// - ROM selects also assert for FE0000-FFFFFF, split by bit 16.
// - Master input high drives CPU upper address out to expansion, low reverses.
// - Hold ack low drives ALE-latched address 17-19 onto system address 17-19.
// - Hold ack high: master high passes 17-19 straight, master low floats them.
// - Address bit 20 follows CPU bit 20 while gate high, forced low otherwise.
// - DMA enable high: system bit 0 to peripheral; low: peripheral to system.
// - Speaker/NMI control port readable and writable at I/O address 61 hex.
// - Writes set speaker and NMI masks; reads give refresh, speaker, NMI sources.
// - NMI on parity error or channel check, each only if its enable bit set.
// - NMI output is masked off after power-up.
// - I/O write to 070 hex: data bit 7 low unmasks NMI, high masks it.
// - Clock chip read/write select is high for read, low for write.
// - Peripheral memory read sets memory bus direction and clocks in parity results.
// - Memory bus direction high for memory to system, low for system to memory.
// - Parity check enable is the OR of the two bank column enables.
// - Peripheral data bus driven only while the control port is read.
`ifndef MDAB_DEFINES_VH
`define MDAB_DEFINES_VH
`define MDAB_IO_AW          10
`define MDAB_CTRL_PORT_ADDR 10'h061
`define MDAB_NMI_MASK_ADDR  10'h070
`define MDAB_CTRL_RST       4'h0
`define MDAB_PB_GATE        0
`define MDAB_PB_SPK         1
`define MDAB_PB_PAR_EN      2
`define MDAB_PB_CHK_EN      3
`define MDAB_PB_REF         4
`define MDAB_PB_OUT2        5
`define MDAB_PB_CHK         6
`define MDAB_PB_PAR         7
`define MDAB_NMI_MASK_BIT   7
`define MDAB_ROM_LOW_BLK    7'h07
`define MDAB_ROM_HIGH_BLK   7'h7F
`define MDAB_DOS_TOP_BLK    7'h05
`define MDAB_MEG_TOP_BLK    7'h08
`endif

// File: verilog/mdab_memory_decode.v
`timescale 1ns/100ps
`default_nettype none
`include "mdab_defines.vh"

module mdab_memory_decode (
    input  wire        clock_i,
    input  wire        nrst_i,
    input  wire [6:0]  cpu_upper_addr_i,
    output reg  [6:0]  cpu_upper_addr_o,
    output reg         cpu_upper_addr_oe_o,
    input  wire [6:0]  expansion_upper_addr_i,
    output reg  [6:0]  expansion_upper_addr_o,
    output reg         expansion_upper_addr_oe_o,
    output reg  [2:0]  system_mid_addr_o,
    output reg         system_mid_addr_oe_o,
    input  wire        bus_master_n_i,
    input  wire        cpu_hold_ack_i,
    input  wire        ram_addr_latch_strobe_i,
    input  wire        addr_latch_enable_i,
    input  wire        refresh_n_i,
    input  wire        refresh_counter_carry_i,
    input  wire        row_col_select_i,
    input  wire        ram_config_strap0_i,
    input  wire        ram_config_strap1_i,
    input  wire        ram_config_strap2_i,
    output reg         bank0_row_enable_o,
    output reg         bank1_row_enable_o,
    output reg         bank0_col_enable_o,
    output reg         bank1_col_enable_o,
    output reg         dram_addr_bit_lo_o,
    output reg         dram_addr_bit_hi_o,
    output reg         parity_check_enable_o,
    input  wire        periph_addr_bit16_i,
    output reg         rom_select_low_n_o,
    output reg         rom_select_high_n_o,
    input  wire        cpu_addr20_in_i,
    input  wire        addr20_gate_i,
    output reg         addr20_o,
    input  wire        dma_addr_enable_n_i,
    input  wire        system_addr0_i,
    output reg         system_addr0_o,
    output reg         system_addr0_oe_o,
    input  wire        periph_addr0_i,
    output reg         periph_addr0_o,
    output reg         periph_addr0_oe_o,
    input  wire [9:0]  io_addr_i,
    input  wire        io_read_n_i,
    input  wire        io_write_n_i,
    input  wire [7:0]  periph_data_bus_i,
    output reg  [7:0]  periph_data_bus_o,
    output reg         periph_data_bus_oe_o,
    input  wire        timer_out2_i,
    output reg         timer_gate2_o,
    output reg         speaker_data_o,
    input  wire        parity_error_n_i,
    input  wire        channel_check_n_i,
    output reg         nmi_o,
    input  wire        periph_mem_read_n_i,
    output reg         mem_bus_direction_n_o,
    input  wire        clock_strobe_enable_n_i,
    input  wire        bus_cycle_phase_i,
    output reg         clock_chip_rw_select_o,
    output reg         clock_chip_addr_strobe_o
);

////////////////////////////////////////////////////////////////////////////////
// RAM decode and latches

    reg  [3:0] ram_dec_q;
    reg  [3:0] ram_dec_d;
    reg  [3:0] ma_q;
    reg        rom_dec_q;
    reg  [2:0] mid_addr_q;
    reg  [6:0] lim0;
    reg  [6:0] lim1;
    reg        b0_hit;
    reg        b1_hit;
    wire [6:0] blk = cpu_upper_addr_i;
    wire [2:0] strap = {ram_config_strap2_i, ram_config_strap1_i, ram_config_strap0_i};
    wire       ram_open = ram_addr_latch_strobe_i | cpu_hold_ack_i;
    wire       ale_open = addr_latch_enable_i | cpu_hold_ack_i;
    wire       refresh  = ~refresh_n_i;
    wire       rom_hit  = (blk == `MDAB_ROM_LOW_BLK)
                        | (blk == `MDAB_ROM_HIGH_BLK);

    // Bank tops in 128K blocks; the region between 640K and 1M is never RAM
    always @* begin
        case (strap)
            3'h1: begin
                lim0 = 7'h04;
                lim1 = 7'h05;
            end
            3'h2: begin
                lim0 = 7'h04;
                lim1 = 7'h0C;
            end
            3'h3: begin
                lim0 = 7'h08;
                lim1 = 7'h10;
            end
            3'h4: begin
                lim0 = 7'h10;
                lim1 = 7'h20;
            end
            default: begin
                lim0 = 7'h02;
                lim1 = 7'h04;
            end
        endcase
        b0_hit = blk < lim0;
        b1_hit = (blk >= lim0) && (blk < lim1);
        if (blk >= `MDAB_DOS_TOP_BLK && blk < `MDAB_MEG_TOP_BLK) begin
            b0_hit = 1'b0;
            b1_hit = 1'b0;
        end
        ram_dec_d = {b1_hit, b0_hit, b1_hit, b0_hit};
    end

    always @(posedge clock_i) begin
        if (!nrst_i) begin
            ram_dec_q  <= 4'h0;
            ma_q       <= 4'h0;
            rom_dec_q  <= 1'b0;
            mid_addr_q <= 3'h0;
        end else begin
            if (ram_open) begin
                ram_dec_q <= ram_dec_d;
                ma_q      <= blk[3:0];
            end
            if (ale_open) begin
                rom_dec_q  <= rom_hit;
                mid_addr_q <= blk[2:0];
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Memory outputs

    wire row0 = refresh | ram_dec_q[0];
    wire row1 = refresh | ram_dec_q[1];
    wire col0 = ~refresh & ram_dec_q[2];
    wire col1 = ~refresh & ram_dec_q[3];

    always @(posedge clock_i) begin
        if (!nrst_i) begin
            bank0_row_enable_o    <= 1'b0;
            bank1_row_enable_o    <= 1'b0;
            bank0_col_enable_o    <= 1'b0;
            bank1_col_enable_o    <= 1'b0;
            parity_check_enable_o <= 1'b0;
            dram_addr_bit_lo_o    <= 1'b0;
            dram_addr_bit_hi_o    <= 1'b0;
            rom_select_low_n_o    <= 1'b1;
            rom_select_high_n_o   <= 1'b1;
            mem_bus_direction_n_o <= 1'b0;
        end else begin
            bank0_row_enable_o    <= row0;
            bank1_row_enable_o    <= row1;
            bank0_col_enable_o    <= col0;
            bank1_col_enable_o    <= col1;
            parity_check_enable_o <= col0 | col1;
            if (refresh)
                dram_addr_bit_lo_o <= refresh_counter_carry_i;
            else
                dram_addr_bit_lo_o <= row_col_select_i ? ma_q[1] : ma_q[0];
            dram_addr_bit_hi_o    <= row_col_select_i ? ma_q[3] : ma_q[2];
            rom_select_low_n_o    <= ~(rom_dec_q & ~periph_addr_bit16_i);
            rom_select_high_n_o   <= ~(rom_dec_q & periph_addr_bit16_i);
            mem_bus_direction_n_o <= ~periph_mem_read_n_i;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Address buffers

    always @(posedge clock_i) begin
        if (!nrst_i) begin
            cpu_upper_addr_o          <= 7'h00;
            cpu_upper_addr_oe_o       <= 1'b0;
            expansion_upper_addr_o    <= 7'h00;
            expansion_upper_addr_oe_o <= 1'b0;
            system_mid_addr_o         <= 3'h0;
            system_mid_addr_oe_o      <= 1'b0;
            addr20_o                  <= 1'b0;
            system_addr0_o            <= 1'b0;
            system_addr0_oe_o         <= 1'b0;
            periph_addr0_o            <= 1'b0;
            periph_addr0_oe_o         <= 1'b0;
        end else begin
            expansion_upper_addr_o    <= cpu_upper_addr_i;
            expansion_upper_addr_oe_o <= bus_master_n_i;
            cpu_upper_addr_o          <= expansion_upper_addr_i;
            cpu_upper_addr_oe_o       <= ~bus_master_n_i;
            if (!cpu_hold_ack_i) begin
                system_mid_addr_o    <= mid_addr_q;
                system_mid_addr_oe_o <= 1'b1;
            end else if (bus_master_n_i) begin
                system_mid_addr_o    <= blk[2:0];
                system_mid_addr_oe_o <= 1'b1;
            end else begin
                system_mid_addr_o    <= mid_addr_q;
                system_mid_addr_oe_o <= 1'b0;
            end
            addr20_o          <= cpu_addr20_in_i & addr20_gate_i;
            periph_addr0_o    <= system_addr0_i;
            periph_addr0_oe_o <= dma_addr_enable_n_i;
            system_addr0_o    <= periph_addr0_i;
            system_addr0_oe_o <= ~dma_addr_enable_n_i;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Control port, NMI and clock chip strobes

    reg  [3:0] ctrl_q;
    reg        nmi_unmask_q;
    reg        parity_flag_q;
    reg        wr_n_q;
    reg        mrd_n_q;
    wire       wr_start  = ~io_write_n_i & wr_n_q;
    wire       mrd_end   = periph_mem_read_n_i & ~mrd_n_q;
    wire       sel_ctrl  = io_addr_i == `MDAB_CTRL_PORT_ADDR;
    wire       sel_mask  = io_addr_i == `MDAB_NMI_MASK_ADDR;
    wire       ctrl_wr   = wr_start & sel_ctrl;
    wire       par_en_d  = ctrl_wr ? periph_data_bus_i[`MDAB_PB_PAR_EN]
                                   : ctrl_q[`MDAB_PB_PAR_EN];
    wire       par_event = mrd_end & ~parity_error_n_i;
    wire       nmi_src   = (parity_flag_q & ctrl_q[`MDAB_PB_PAR_EN])
                         | (~channel_check_n_i & ctrl_q[`MDAB_PB_CHK_EN]);
    wire [7:0] ctrl_rd   = {parity_flag_q, ~channel_check_n_i, timer_out2_i, refresh, ctrl_q};

    always @(posedge clock_i) begin
        if (!nrst_i) begin
            ctrl_q        <= `MDAB_CTRL_RST;
            nmi_unmask_q  <= 1'b0;
            parity_flag_q <= 1'b0;
            wr_n_q        <= 1'b1;
            mrd_n_q       <= 1'b1;
        end else begin
            wr_n_q  <= io_write_n_i;
            mrd_n_q <= periph_mem_read_n_i;
            if (ctrl_wr)
                ctrl_q <= periph_data_bus_i[3:0];
            if (wr_start && sel_mask)
                nmi_unmask_q <= ~periph_data_bus_i[`MDAB_NMI_MASK_BIT];
            // A new error wins over disabling the check in the same cycle
            if (par_event)
                parity_flag_q <= 1'b1;
            else if (!par_en_d)
                parity_flag_q <= 1'b0;
        end
    end

    always @(posedge clock_i) begin
        if (!nrst_i) begin
            periph_data_bus_o        <= 8'h00;
            periph_data_bus_oe_o     <= 1'b0;
            timer_gate2_o            <= 1'b0;
            speaker_data_o           <= 1'b0;
            nmi_o                    <= 1'b0;
            clock_chip_rw_select_o   <= 1'b1;
            clock_chip_addr_strobe_o <= 1'b0;
        end else begin
            periph_data_bus_o        <= ctrl_rd;
            periph_data_bus_oe_o     <= ~io_read_n_i & sel_ctrl;
            timer_gate2_o            <= ctrl_q[`MDAB_PB_GATE];
            speaker_data_o           <= ctrl_q[`MDAB_PB_SPK] & timer_out2_i;
            nmi_o                    <= nmi_unmask_q & nmi_src;
            clock_chip_rw_select_o   <= io_write_n_i;
            clock_chip_addr_strobe_o <= ~clock_strobe_enable_n_i & bus_cycle_phase_i
                                      & sel_mask & ~io_write_n_i;
        end
    end

endmodule

`default_nettype wire

// File: test/mdab_memory_decode_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module mdab_memory_decode_assertions (
    input wire logic clock_i, nrst_i, addr20_o, cpu_addr20_in_i, addr20_gate_i,
    input wire logic mem_bus_direction_n_o, periph_mem_read_n_i, refresh_n_i,
    input wire logic bank0_row_enable_o, bank1_row_enable_o, bank0_col_enable_o,
    input wire logic bank1_col_enable_o, parity_check_enable_o, rom_select_low_n_o,
    input wire logic periph_addr_bit16_i, periph_addr0_oe_o, system_addr0_oe_o,
    input wire logic dma_addr_enable_n_i, expansion_upper_addr_oe_o, cpu_upper_addr_oe_o,
    input wire logic bus_master_n_i, clock_chip_rw_select_o, io_write_n_i
);
    logic up_q = 1'b0;
    // Out of reset for a full cycle, so past inputs are meaningful
    always @(posedge clock_i) begin
        up_q <= nrst_i;
    end
    default clocking dcb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    chk_addr20_gate: assert property (up_q |->
        addr20_o == $past(cpu_addr20_in_i && addr20_gate_i)) else $error("addr20 wrong");
    chk_mem_dir: assert property (up_q |->
        mem_bus_direction_n_o == !$past(periph_mem_read_n_i)) else $error("mem dir wrong");
    chk_refresh_force: assert property (up_q && $past(!refresh_n_i) |->
        {bank1_row_enable_o, bank0_row_enable_o, bank1_col_enable_o, bank0_col_enable_o}
        == 4'hC) else $error("refresh banks wrong");
    chk_parity_or: assert property (parity_check_enable_o ==
        (bank0_col_enable_o || bank1_col_enable_o)) else $error("parity enable wrong");
    chk_rom_split: assert property (!rom_select_low_n_o |->
        !$past(periph_addr_bit16_i)) else $error("rom low select wrong");
    chk_addr0_dir: assert property (up_q |-> periph_addr0_oe_o ==
        $past(dma_addr_enable_n_i) && system_addr0_oe_o != periph_addr0_oe_o)
        else $error("addr0 direction wrong");
    chk_upper_dir: assert property (up_q |-> expansion_upper_addr_oe_o ==
        $past(bus_master_n_i) && cpu_upper_addr_oe_o != expansion_upper_addr_oe_o)
        else $error("upper address direction wrong");
    chk_rtc_rw: assert property (up_q |->
        clock_chip_rw_select_o == $past(io_write_n_i)) else $error("rtc rw wrong");
endmodule
`default_nettype wire

// File: test/mdab_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module mdab_bus_model (
    input  wire logic       clock_i,
    input  wire logic [7:0] periph_data_bus_o,
    input  wire logic       periph_data_bus_oe_o,
    input  wire logic [7:0] host_data,
    input  wire logic       host_drive,
    input  wire logic       timer_gate2_o,
    output logic      [7:0] periph_data_bus_i,
    output logic            timer_out2_i = 1'b0
);
    logic flip_q = 1'b0;
    // A released bus shows a changing pattern, never the last driven value
    assign periph_data_bus_i = periph_data_bus_oe_o ? periph_data_bus_o :
                               host_drive ? host_data : (8'hA5 ^ {8{flip_q}});
    // Timer output only moves while its gate is open
    always @(posedge clock_i) begin
        flip_q <= ~flip_q;
        if (timer_gate2_o) begin
            timer_out2_i <= ~timer_out2_i;
        end
    end
endmodule
`default_nettype wire

// File: test/tb_mdab_memory_decode.sv
`timescale 1ns/100ps
`default_nettype none
module tb_mdab_memory_decode;
    logic clock_i, nrst_i, bus_master_n_i, cpu_hold_ack_i, ram_addr_latch_strobe_i, sa0_x;
    logic addr_latch_enable_i, refresh_n_i, refresh_counter_carry_i, row_col_select_i, xa0_x;
    logic periph_addr_bit16_i, cpu_addr20_in_i, addr20_gate_i, dma_addr_enable_n_i;
    logic io_read_n_i, io_write_n_i, parity_error_n_i, channel_check_n_i, periph_mem_read_n_i;
    logic clock_strobe_enable_n_i, host_drive, timer_out2_i, cpu_upper_addr_oe_o, nmi_o;
    logic [6:0] a_x, la_x, cpu_upper_addr_o, expansion_upper_addr_o;
    logic [7:0] host_data, periph_data_bus_i, periph_data_bus_o;
    logic [9:0] io_addr_i;
    logic [2:0] system_mid_addr_o;
    logic expansion_upper_addr_oe_o, system_mid_addr_oe_o, bank0_row_enable_o, addr20_o;
    logic bank1_row_enable_o, bank0_col_enable_o, bank1_col_enable_o, dram_addr_bit_lo_o;
    logic dram_addr_bit_hi_o, parity_check_enable_o, rom_select_low_n_o, rom_select_high_n_o;
    logic system_addr0_o, system_addr0_oe_o, periph_addr0_o, periph_addr0_oe_o, speaker_data_o;
    logic periph_data_bus_oe_o, timer_gate2_o, mem_bus_direction_n_o, clock_chip_rw_select_o;
    logic clock_chip_addr_strobe_o, bus_cycle_phase_i;
    int num_errors, compares, cyc_cnt;
    wire logic [6:0] cpu_upper_addr_i = cpu_upper_addr_oe_o ? cpu_upper_addr_o : a_x;
    wire logic [6:0] expansion_upper_addr_i = expansion_upper_addr_oe_o ? expansion_upper_addr_o : la_x;
    wire logic system_addr0_i = system_addr0_oe_o ? system_addr0_o : sa0_x;
    wire logic periph_addr0_i = periph_addr0_oe_o ? periph_addr0_o : xa0_x;
    wire logic ram_config_strap0_i = 1'b0;
    wire logic ram_config_strap1_i = 1'b0;
    wire logic ram_config_strap2_i = 1'b0;
    // Address, bank16, expected {low_n, high_n}
    localparam logic [9:0] ROM_TBL [7] = '{10'h039, 10'h03E, 10'h3F9, 10'h3FE, 10'h033,
                                           10'h047, 10'h3F7};
    // {hold, strobe, col, refresh_n, carry}, address, expected {rows, cols, hi, lo}
    localparam logic [17:0] RAM_TBL [7] = '{{5'h0A, 7'h00, 6'h14}, {5'h0A, 7'h03, 6'h29},
        {5'h02, 7'h00, 6'h29}, {5'h12, 7'h00, 6'h14}, {5'h0A, 7'h05, 6'h03},
        {5'h0E, 7'h05, 6'h00}, {5'h0D, 7'h05, 6'h31}};

    mdab_memory_decode i_dut (.*);
    mdab_bus_model i_bus (.*);

    always #50 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            num_errors++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [9:0] a, input logic [7:0] d);
        cyc(1);
        {io_addr_i, host_data, host_drive, io_write_n_i} <= {a, d, 2'b10};
        cyc(1);
        {host_drive, io_write_n_i} <= 2'b01;
    endtask
    task rd(input logic [7:0] e, input string n);
        cyc(1);
        {io_addr_i, io_read_n_i} <= {10'h061, 1'b0};
        cyc(2);
        #1 chk(n, periph_data_bus_o, e);
        chk("read enable", periph_data_bus_oe_o, 1);
        cyc(1);
        io_read_n_i <= 1'b1;
    endtask
    task end_sim();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {clock_i, nrst_i, cpu_hold_ack_i, ram_addr_latch_strobe_i, addr_latch_enable_i, sa0_x,
         refresh_counter_carry_i, row_col_select_i, periph_addr_bit16_i, cpu_addr20_in_i,
         addr20_gate_i, host_drive, xa0_x, a_x, la_x, host_data, io_addr_i,
         bus_cycle_phase_i} = '0;
        {refresh_n_i, dma_addr_enable_n_i, io_read_n_i, io_write_n_i, parity_error_n_i,
         channel_check_n_i, periph_mem_read_n_i, clock_strobe_enable_n_i, bus_master_n_i} = '1;
        num_errors = 0;
        compares = 0;
        cyc_cnt = 0;
        cyc(12);
        nrst_i <= 1'b1;
        cyc(1);
        clock_strobe_enable_n_i <= 1'b0;
        #1 chk("nmi reset", nmi_o, 0);
        wr(10'h061, 8'h0E);
        rd(8'h0E, "port");
        wr(10'h070, 8'h00);
        wr(10'h061, 8'h08);
        channel_check_n_i <= 1'b0;
        cyc(2);
        #1 chk("nmi check", nmi_o, 1);
        rd(8'h48, "port check");
        wr(10'h070, 8'h80);
        cyc(2);
        #1 chk("nmi masked", nmi_o, 0);
        wr(10'h070, 8'h00);
        channel_check_n_i <= 1'b1;
        wr(10'h061, 8'h04);
        {periph_mem_read_n_i, parity_error_n_i} <= 2'b00;
        cyc(2);
        #1 chk("mem dir", mem_bus_direction_n_o, 1);
        cyc(1);
        periph_mem_read_n_i <= 1'b1;
        cyc(2);
        #1 chk("nmi parity", nmi_o, 1);
        rd(8'h84, "port parity");
        parity_error_n_i <= 1'b1;
        wr(10'h061, 8'h00);
        cyc(2);
        #1 chk("nmi cleared", nmi_o, 0);
        $display("test port done");
        for (int i = 0; i < 7; i++) begin
            cyc(1);
            {addr_latch_enable_i, a_x, periph_addr_bit16_i} <= {1'b1, ROM_TBL[i][9:2]};
            cyc(2);
            #1 chk("rom", {rom_select_low_n_o, rom_select_high_n_o}, ROM_TBL[i][1:0]);
        end
        cyc(1);
        {addr_latch_enable_i, a_x} <= {1'b0, 7'h7F};
        cyc(2);
        #1 chk("rom held", {rom_select_low_n_o, rom_select_high_n_o}, 3);
        cyc(1);
        cpu_hold_ack_i <= 1'b1;
        cyc(2);
        #1 chk("rom hold", {rom_select_low_n_o, rom_select_high_n_o}, 2);
        for (int i = 0; i < 7; i++) begin
            cyc(1);
            {cpu_hold_ack_i, ram_addr_latch_strobe_i, row_col_select_i, refresh_n_i,
             refresh_counter_carry_i, a_x} <= RAM_TBL[i][17:6];
            cyc(2);
            #1 chk("ram", {bank1_row_enable_o, bank0_row_enable_o, bank1_col_enable_o,
                bank0_col_enable_o, dram_addr_bit_hi_o, dram_addr_bit_lo_o}, RAM_TBL[i][5:0]);
        end
        $display("test memory done");
        cyc(1);
        {refresh_n_i, bus_master_n_i, cpu_hold_ack_i, la_x} <= {3'h5, 7'h55};
        cyc(2);
        #1 chk("cpu upper", {cpu_upper_addr_oe_o, cpu_upper_addr_o}, 8'hD5);
        chk("mid float", system_mid_addr_oe_o, 0);
        cyc(1);
        {bus_master_n_i, a_x} <= {1'b1, 7'h2A};
        cyc(2);
        #1 chk("exp upper", {expansion_upper_addr_oe_o, expansion_upper_addr_o}, 8'hAA);
        chk("mid pass", {system_mid_addr_oe_o, system_mid_addr_o}, 8'h0A);
        cyc(1);
        {addr_latch_enable_i, cpu_hold_ack_i, a_x} <= {2'h2, 7'h15};
        cyc(2);
        #1 chk("mid latch", {system_mid_addr_oe_o, system_mid_addr_o}, 8'h0D);
        cyc(1);
        {addr_latch_enable_i, a_x} <= 8'h00;
        cyc(2);
        #1 chk("mid held", {system_mid_addr_oe_o, system_mid_addr_o}, 8'h0D);
        for (int i = 0; i < 4; i++) begin
            cyc(1);
            {addr20_gate_i, cpu_addr20_in_i} <= i[1:0];
            cyc(2);
            #1 chk("a20", addr20_o, i == 3);
        end
        cyc(1);
        {dma_addr_enable_n_i, sa0_x, xa0_x} <= 3'h6;
        cyc(2);
        #1 chk("periph a0", {periph_addr0_oe_o, periph_addr0_o}, 8'h03);
        cyc(1);
        {dma_addr_enable_n_i, sa0_x, xa0_x} <= 3'h1;
        cyc(2);
        #1 chk("system a0", {system_addr0_oe_o, system_addr0_o}, 8'h03);
        wr(10'h061, 8'h03);
        cyc(5);
        #1 chk("gate", timer_gate2_o, 1);
        wr(10'h061, 8'h02);
        cyc(3);
        #1 chk("speaker", speaker_data_o, timer_out2_i);
        rd({2'h0, timer_out2_i, 5'h02}, "port speaker");
        cyc(1);
        {io_addr_i, bus_cycle_phase_i, io_write_n_i} <= {10'h070, 2'b10};
        cyc(2);
        #1 chk("rtc strobe", clock_chip_addr_strobe_o, 1);
        chk("rtc write", clock_chip_rw_select_o, 0);
        cyc(1);
        {bus_cycle_phase_i, io_write_n_i} <= 2'b01;
        cyc(2);
        #1 chk("rtc idle", clock_chip_addr_strobe_o, 0);
        $display("test address done");
        end_sim();
    end
endmodule
bind mdab_memory_decode mdab_memory_decode_assertions u_chk (.*);
`default_nettype wire
